// ==== rtl/wdt_pkg.sv ====
package wdt_pkg;
	// Register byte addresses
	localparam logic [7:0] WDT_CTRL1_ADDR  = 8'h34;
	localparam logic [7:0] WDT_CLEAR_ADDR  = 8'h38;
	localparam logic [7:0] WDT_STAT_ADDR   = 8'h3C;
	localparam logic [7:0] WDT_MASK_ADDR   = 8'h40;
	localparam logic [7:0] WDT_STATE_ADDR  = 8'h44;
	// Control one layout and reset value (upper four bits read as one)
	localparam int         WDT_EN_BIT      = 3;
	localparam int         WDT_TIME_LO     = 1;
	localparam int         WDT_ACT_BIT     = 0;
	localparam logic [7:0] WDT_CTRL1_RST   = 8'hF9;
	localparam logic [7:0] WDT_CTRL1_RSVD  = 8'hC0;
	// Clear code
	localparam logic [7:0] WDT_CLEAR_CODE  = 8'h4E;
	// Status bits
	localparam int         WDT_ST_OVF      = 0;
	localparam int         WDT_ST_RST      = 1;
	// Divider width; taps per detection time select
	localparam int         WDT_DIV_W       = 25;
	localparam int         WDT_TAP0        = 10;
	localparam int         WDT_TAP1        = 12;
	localparam int         WDT_TAP2        = 14;
	localparam int         WDT_TAP3        = 16;
	// Reset pin low pulse length in cycles
	localparam int         WDT_RST_CYC     = 16;
endpackage : wdt_pkg

// ==== rtl/wdt_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// Divider counting only while run_i is high: one-cycle pulse on the rising edge of a selected tap
module wdt_divider
	import wdt_pkg::*;
(
	// System
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       run_i,
	input  wire logic [1:0] sel_i,
	// Tick out
	output logic            tick_o
);
	logic [WDT_DIV_W-1:0] cnt_r;
	logic [WDT_DIV_W-1:0] cnt_nxt;
	wire  [3:0]           taps_now;
	wire  [3:0]           taps_nxt;

	// Divider never cleared by software, only by chip reset
	assign cnt_nxt  = cnt_r + {{(WDT_DIV_W-1){1'b0}}, 1'b1};
	assign taps_now = {cnt_r[WDT_TAP3], cnt_r[WDT_TAP2], cnt_r[WDT_TAP1], cnt_r[WDT_TAP0]};
	assign taps_nxt = {cnt_nxt[WDT_TAP3], cnt_nxt[WDT_TAP2], cnt_nxt[WDT_TAP1],
		cnt_nxt[WDT_TAP0]};
	assign tick_o   = run_i & taps_nxt[sel_i] & ~taps_now[sel_i];

	// Divider advances only while not frozen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else if (run_i) begin
			cnt_r <= cnt_nxt;
		end
	end

	a_div_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!run_i |=> $stable(cnt_r))
		else $error("divider moved while frozen");
endmodule : wdt_divider
`default_nettype wire

// ==== rtl/wdt_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watchdog with Wishbone register access
module wdt_top
	import wdt_pkg::*;
(
	// System
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Wishbone slave
	input  wire logic       cyc_i,
	input  wire logic       stb_i,
	input  wire logic       we_i,
	input  wire logic [7:0] adr_i,
	input  wire logic [3:0] sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]     dat_o,
	output logic            ack_o,
	// Power modes
	input  wire logic       stop_i,
	input  wire logic       warmup_i,
	input  wire logic       idle_i,
	input  wire logic       sleep_i,
	// Events
	output logic            reset_pin_n_o,
	output logic            reset_req_o,
	output logic            irq_o
);
	logic [2:0]  ctrl_r;        // enable, time[1:0] stored low three; action separate
	logic        act_r;
	logic        act_locked_r;
	logic [1:0]  bin_r;
	logic [1:0]  stat_r;
	logic [1:0]  mask_r;
	logic [4:0]  rst_cnt_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic        tick;

	// Bus decode
	wire req       = cyc_i & stb_i & ~ack_r;
	wire wr        = req & we_i & sel_i[0];
	wire hit_ctrl  = adr_i == WDT_CTRL1_ADDR;
	wire hit_clear = adr_i == WDT_CLEAR_ADDR;
	wire hit_stat  = adr_i == WDT_STAT_ADDR;
	wire hit_mask  = adr_i == WDT_MASK_ADDR;
	wire hit_state = adr_i == WDT_STATE_ADDR;
	wire wr_ctrl   = wr & hit_ctrl;
	wire wr_clear  = wr & hit_clear & (dat_i[7:0] == WDT_CLEAR_CODE);
	wire wr_stat   = wr & hit_stat;
	wire wr_mask   = wr & hit_mask;

	// Counting conditions
	wire frozen    = stop_i | warmup_i | idle_i | sleep_i;
	wire enabled   = ctrl_r[WDT_EN_BIT-1];
	wire run       = enabled & ~frozen;
	wire ovf       = tick & (bin_r == 2'b11);
	wire ovf_rst   = ovf & act_r;
	wire ovf_irq   = ovf & ~act_r;
	wire [7:0] ctrl_view = {WDT_CTRL1_RST[7:4], ctrl_r, act_r}; // Upper nibble reads fixed

	// Read mux
	wire [31:0] rd_data =
		hit_ctrl  ? {24'h0, ctrl_view} :
		hit_stat  ? {30'h0, stat_r} :
		hit_mask  ? {30'h0, mask_r} :
		hit_state ? {29'h0, act_locked_r, bin_r} : 32'h0;

	wdt_divider u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (run),
		.sel_i  (ctrl_r[1:0]),
		.tick_o (tick)
	);

	// Bus answer one cycle after request; unmapped reads zero, writes ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= req;
			dat_r <= req ? rd_data : dat_r;
		end
	end
	assign ack_o = ack_r;
	assign dat_o = dat_r;

	// Control one; action bit writable once after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r       <= WDT_CTRL1_RST[3:1];
			act_r        <= WDT_CTRL1_RST[WDT_ACT_BIT];
			act_locked_r <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl_r       <= dat_i[3:1];
			act_locked_r <= 1'b1;
			if (!act_locked_r) begin
				act_r <= dat_i[WDT_ACT_BIT];
			end
		end
	end

	// Two-stage binary counter; clear leaves divider alone, wraps for periodic use
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bin_r <= 2'b00;
		end else if (wr_clear) begin
			bin_r <= 2'b00;
		end else if (tick) begin
			bin_r <= bin_r + 2'b01;
		end
	end

	// Sticky bit next value: a new event wins over a write-one clear
	function automatic logic sticky_nxt(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction : sticky_nxt

	// Sticky status: set wins over write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_r <= 2'b00;
			mask_r <= 2'b00;
		end else begin
			stat_r[WDT_ST_OVF] <= sticky_nxt(stat_r[WDT_ST_OVF], ovf_irq,
				wr_stat & dat_i[WDT_ST_OVF]);
			stat_r[WDT_ST_RST] <= sticky_nxt(stat_r[WDT_ST_RST], ovf_rst,
				wr_stat & dat_i[WDT_ST_RST]);
			if (wr_mask) begin
				mask_r <= dat_i[1:0];
			end
		end
	end
	assign irq_o = |(stat_r & mask_r);

	// Reset pin low pulse after reset-type overflow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_cnt_r <= 5'd0;
		end else if (ovf_rst) begin
			rst_cnt_r <= 5'(WDT_RST_CYC);
		end else if (rst_cnt_r != 5'd0) begin
			rst_cnt_r <= rst_cnt_r - 5'd1;
		end
	end
	assign reset_pin_n_o = (rst_cnt_r == 5'd0);
	assign reset_req_o   = (rst_cnt_r != 5'd0);

	// Checks
	a_act_default: assert property (@(posedge clk_i)
		$fell(rst_i) |-> act_r && !act_locked_r)
		else $error("action not reset request after reset");
	a_act_once: assert property (@(posedge clk_i) disable iff (rst_i)
		act_locked_r |=> $stable(act_r))
		else $error("action changed after lock");
	a_auto_en: assert property (@(posedge clk_i)
		$fell(rst_i) |-> enabled)
		else $error("watchdog not enabled after reset");
	sequence s_ovf_rst;
		ovf && act_r;
	endsequence
	a_rst_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		s_ovf_rst |=> !reset_pin_n_o [*8])
		else $error("reset pin not held low");
	a_irq_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf && !act_r |=> stat_r[WDT_ST_OVF] && reset_pin_n_o)
		else $error("overflow interrupt flag not set");
	a_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
		frozen && !wr_clear |=> $stable(bin_r))
		else $error("counter moved while frozen");
	a_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_clear |=> bin_r == 2'b00)
		else $error("clear code did not clear counter");
	a_ovf_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(stat_r[WDT_ST_OVF]) |-> $past(bin_r) == 2'b11)
		else $error("overflow flag without full counter");
	a_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf && !wr_clear |=> bin_r == 2'b00)
		else $error("counter did not wrap for periodic use");
	a_ctrl_rst: assert property (@(posedge clk_i)
		$fell(rst_i) |-> ctrl_view == WDT_CTRL1_RST)
		else $error("control one reset value wrong");

	a_out_reset: assert property (@(posedge clk_i)
		$fell(rst_i) |-> reset_pin_n_o && !irq_o && !ack_o)
		else $error("outputs not idle after reset");

	// Bus handshake checks
	sequence s_bus_req;
		cyc_i && stb_i && !ack_o;
	endsequence

	a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
		s_bus_req |=> ack_o)
		else $error("bus request not acknowledged");

	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("acknowledge longer than one cycle");

	a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		!(cyc_i && stb_i) |=> !ack_o)
		else $error("acknowledge without request");

	a_rd_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
		s_bus_req && !we_i && hit_ctrl |=> dat_o[7:4] == WDT_CTRL1_RST[7:4])
		else $error("control one fixed bits wrong");

	a_rd_unmap: assert property (@(posedge clk_i) disable iff (rst_i)
		s_bus_req && !we_i && !(hit_ctrl || hit_stat || hit_mask || hit_state)
		|=> dat_o == 32'h0)
		else $error("unmapped read not zero");

	// Control one and action lock checks
	a_lock_set: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl |=> act_locked_r)
		else $error("action not locked after control write");

	a_first_act: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && !act_locked_r |=> act_r == $past(dat_i[WDT_ACT_BIT]))
		else $error("first action write lost");

	a_ctrl_wr: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl |=> ctrl_r == $past(dat_i[3:1]))
		else $error("control one write lost");

	// Counter checks
	a_bad_code: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_clear && dat_i[7:0] != WDT_CLEAR_CODE && !tick |=> $stable(bin_r))
		else $error("wrong code cleared counter");

	a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && !wr_clear |=> bin_r == $past(bin_r) + 2'b01)
		else $error("counter did not step on tick");

	a_tick_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!tick && !wr_clear |=> $stable(bin_r))
		else $error("counter moved without tick");

	a_freeze_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		frozen |-> !tick)
		else $error("tick while frozen");

	a_dis_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		!enabled |-> !tick)
		else $error("tick while disabled");

	// Reset pin checks
	a_pin_pair: assert property (@(posedge clk_i) disable iff (rst_i)
		reset_pin_n_o != reset_req_o)
		else $error("reset pin and request disagree");

	a_pin_end: assert property (@(posedge clk_i) disable iff (rst_i)
		s_ovf_rst |-> ##17 reset_pin_n_o)
		else $error("reset pin not released");

	a_rst_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		s_ovf_rst |=> stat_r[WDT_ST_RST])
		else $error("reset overflow flag not set");

	// Length of the current reset pin low phase, for the pulse-length check
	logic [5:0] pin_low_cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i || reset_pin_n_o) begin
			pin_low_cnt_r <= 6'h00;
		end else begin
			pin_low_cnt_r <= pin_low_cnt_r + 6'h01;
		end
	end

	a_pin_len: assert property (@(posedge clk_i) disable iff (rst_i)
		pin_low_cnt_r <= 6'(WDT_RST_CYC))
		else $error("reset pin low too long");

	// Interrupt path checks
	sequence s_ovf_irq;
		ovf && !act_r;
	endsequence

	a_irq_no_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		s_ovf_irq |=> !reset_req_o)
		else $error("reset request on interrupt overflow");

	a_stat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		stat_r[WDT_ST_OVF] && !(wr_stat && dat_i[WDT_ST_OVF]) |=> stat_r[WDT_ST_OVF])
		else $error("overflow flag lost");

	a_stat_clr: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_stat && dat_i[WDT_ST_OVF] && !ovf_irq |=> !stat_r[WDT_ST_OVF])
		else $error("overflow flag not cleared");

	a_mask_wr: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_mask |=> mask_r == $past(dat_i[1:0]))
		else $error("mask write lost");

endmodule : wdt_top
`default_nettype wire

// ==== test/wdt_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdt_top_tb
	import wdt_pkg::*;
;
	// Bench drive
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [3:0]  pm    = 4'h0;
	// Design outputs
	wire  [31:0] dat_o;
	wire         ack_o;
	wire         reset_pin_n_o;
	wire         reset_req_o;
	wire         irq_o;
	// Bench state
	logic [31:0] rd;
	logic [31:0] held;
	int          error_cnt = 0;
	int          checked   = 0;
	int          n;

	// 100 MHz clock
	always #5 clk_i = ~clk_i;

	// Power modes ride on one shifting vector
	wdt_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.stop_i(pm[0]), .warmup_i(pm[1]), .idle_i(pm[2]), .sleep_i(pm[3]),
		.reset_pin_n_o(reset_pin_n_o), .reset_req_o(reset_req_o), .irq_o(irq_o));

	// Closing report
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	// Classic cycle; request held until ack is sampled, data taken there
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1)
				break;
		end
		if (k == 20) begin
			chk("ack", 1, 0);
			end_of_test();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// Main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, WDT_CTRL1_ADDR, 0);
		chk("ctrl1 reset", {24'h0, WDT_CTRL1_RST}, rd);
		wb(0, 8'h50, 0);
		chk("unmapped", 32'h0, rd);
		wb(1, WDT_MASK_ADDR, 32'h3);
		// Untouched watchdog runs on its own and fires a reset overflow
		for (n = 0; n < 20000 && reset_pin_n_o !== 1'b0; n++)
			@(posedge clk_i);
		chk("pin low", 0, reset_pin_n_o);
		if (n == 20000)
			end_of_test();
		chk("reset req", 1, reset_req_o);
		for (n = 0; n < 40 && reset_pin_n_o === 1'b0; n++)
			@(posedge clk_i);
		chk("pin low cycles", WDT_RST_CYC, n);
		chk("irq on overflow", 1, irq_o);
		// Each low-power mode in turn, longer than one tick in total
		pm <= 4'h1;
		wb(0, WDT_STATE_ADDR, 0);
		held = rd;
		repeat (3) begin
			repeat (9000) @(posedge clk_i);
			pm <= pm << 1;
		end
		repeat (9000) @(posedge clk_i);
		wb(0, WDT_STATE_ADDR, 0);
		chk("frozen count", held, rd);
		pm <= 4'h0;
		wb(1, WDT_STAT_ADDR, 32'h3);
		@(posedge clk_i);
		chk("irq cleared", 0, irq_o);
		// Select interrupt action; a second write must not change it
		wb(1, WDT_CTRL1_ADDR, 32'h08);
		wb(1, WDT_CTRL1_ADDR, 32'h09);
		wb(0, WDT_CTRL1_ADDR, 0);
		chk("action locked", 32'hF8, rd);
		wb(1, WDT_CLEAR_ADDR, 32'h4D);
		wb(1, WDT_CLEAR_ADDR, {24'h0, WDT_CLEAR_CODE});
		wb(0, WDT_STATE_ADDR, 0);
		chk("cleared state", 32'h4, rd);
		// Cleared well inside three quarters of the period: no overflow
		repeat (4) begin
			repeat (4000) @(posedge clk_i);
			wb(1, WDT_CLEAR_ADDR, {24'h0, WDT_CLEAR_CODE});
		end
		chk("serviced irq", 0, irq_o);
		for (n = 0; n < 20000 && irq_o !== 1'b1; n++)
			@(posedge clk_i);
		chk("irq overflow", 1, irq_o);
		chk("pin idle", 1, reset_pin_n_o);
		wb(0, WDT_STAT_ADDR, 0);
		chk("status", 32'h1, rd);
		// Left alone, the interrupt recurs one detection period later
		wb(1, WDT_STAT_ADDR, 32'h1);
		for (n = 0; n < 20000 && irq_o !== 1'b1; n++)
			@(posedge clk_i);
		chk("period cycles", 1, n > 8100 && n <= 8192);
		end_of_test();
	end
endmodule : wdt_top_tb
`default_nettype wire
